/* include/sbg_defines.vh */
// Register offsets, field positions, reset values and timing counts of the break generator
`ifndef SBG_DEFINES_VH
`define SBG_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SBG_OFS_CTRL 4'h0
`define SBG_OFS_BAUD 4'h4
`define SBG_OFS_STAT 4'h8

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SBG_CTRL_BRK 0
`define SBG_CTRL_TXEN 1
`define SBG_CTRL_WLEN 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SBG_CTRL_RST 3'h0
`define SBG_BAUD_RST 16'h0363

// ----------------------------------------
// Character lengths in bit periods
// ----------------------------------------
`define SBG_BITS_SHORT 4'hA
`define SBG_BITS_LONG 4'hB

`endif

/* core/sbg_baud_tick.v */
// Bit-period tick generator driven by the baud divisor
module sbg_baud_tick (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Control
   input wire run_i,
   input wire [15:0] div_i,
   // Tick
   output wire tick_o
);

   reg [15:0] cnt_reg;
   reg [15:0] cnt_next;

   // Restart on run so the first bit is a full period
   always @* begin
      cnt_next = cnt_reg;
      if (!run_i || cnt_reg >= div_i) begin
         cnt_next = 16'h0000;
      end else begin
         cnt_next = cnt_reg + 16'h0001;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign tick_o = run_i && (cnt_reg >= div_i);

endmodule

/* core/sbg_break_gen.v */
// Break and idle frame generator of the serial transmit path with a Wishbone slave
`include "sbg_defines.vh"

// Overview of operation
// - Setting then clearing break_request sends exactly one break character at line low.
// - Break lasts 10 bit periods with word length 0, 11 with 1; never doubled.
// - While break_request stays set, consecutive break characters keep being sent.
// - Clearing then setting tx_enable queues an idle frame sent before anything following.
// - Idle immediately followed by break yields a break of exactly nominal length.
module sbg_break_gen (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output wire ack_o,
   // Transmit line
   output reg txd_o,
   output reg busy_o
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam S_IDLE = 2'b00;
   localparam S_IDLEFR = 2'b01;
   localparam S_BREAK = 2'b10;
   // Divisor byte lanes
   localparam NUM_LANES = 2;

   // ----------------------------------------
   // Bus registers
   // ----------------------------------------
   reg [2:0] ctrl_reg;
   reg [2:0] ctrl_next;
   reg [15:0] baud_reg;
   reg ack_reg;
   reg ack_next;
   reg [31:0] rdata_next;

   // ----------------------------------------
   // Request and sequencer registers
   // ----------------------------------------
   reg brk_pend_reg;
   reg brk_pend_next;
   reg idle_pend_reg;
   reg idle_pend_next;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [3:0] bit_cnt_reg;
   reg [3:0] bit_cnt_next;
   reg [3:0] len_reg;
   reg [3:0] len_next;
   reg [15:0] div_reg;
   reg [15:0] div_next;
   reg [31:0] brk_count_reg;
   reg [31:0] brk_count_next;
   reg txd_next;
   reg busy_next;

   // ----------------------------------------
   // Internal nets
   // ----------------------------------------
   wire tick;
   wire bus_req;
   wire wr_stb;
   wire rd_stb;
   wire ctrl_hit;
   wire baud_hit;
   wire stat_hit;
   wire wr_ctrl;
   wire wr_baud;
   wire brk_bit;
   wire txen_bit;
   wire [3:0] char_len;
   wire [15:0] baud_wr;
   wire [31:0] stat_word;
   wire brk_rise;
   wire txen_rise;
   wire boundary;
   wire frame_end;
   wire take_idle;
   wire take_brk;
   wire line_run;

   assign brk_bit = ctrl_reg[`SBG_CTRL_BRK];
   assign txen_bit = ctrl_reg[`SBG_CTRL_TXEN];
   assign char_len = ctrl_reg[`SBG_CTRL_WLEN] ? `SBG_BITS_LONG : `SBG_BITS_SHORT;

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   // One wait state: read data is fetched when the strobe is first seen,
   // the write lands on the edge at which the master samples ack
   assign bus_req = cyc_i && stb_i;
   assign wr_stb = bus_req && we_i && ack_reg;
   assign rd_stb = bus_req && !we_i && !ack_reg;
   assign ack_o = ack_reg;

   // Address decode
   assign ctrl_hit = (adr_i == `SBG_OFS_CTRL);
   assign baud_hit = (adr_i == `SBG_OFS_BAUD);
   assign stat_hit = (adr_i == `SBG_OFS_STAT);
   assign wr_ctrl = wr_stb && ctrl_hit && sel_i[0];
   assign wr_baud = wr_stb && baud_hit;

   always @* begin
      ack_next = bus_req && !ack_reg;
   end

   always @* begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = dat_i[2:0];
      end
   end

   // Byte lanes of the divisor, each gated by its own select
   genvar lane;
   generate
      for (lane = 0; lane < NUM_LANES; lane = lane + 1) begin : g_baud_lane
         assign baud_wr[lane*8 +: 8] = (wr_baud && sel_i[lane]) ? dat_i[lane*8 +: 8] : baud_reg[lane*8 +: 8];
      end
   endgenerate

   // Status word: count, pending flags, state
   assign stat_word = {brk_count_reg[27:0], idle_pend_reg, brk_pend_reg, state_reg};

   always @* begin
      rdata_next = dat_o;
      if (rd_stb) begin
         if (ctrl_hit) begin
            rdata_next = {29'h00000000, ctrl_reg};
         end else if (baud_hit) begin
            rdata_next = {16'h0000, baud_reg};
         end else if (stat_hit) begin
            rdata_next = stat_word;
         end else begin
            // Unmapped offsets read as zero, writes to them are dropped
            rdata_next = 32'h00000000;
         end
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= ack_next;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= `SBG_CTRL_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         baud_reg <= `SBG_BAUD_RST;
      end else begin
         baud_reg <= baud_wr;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h00000000;
      end else begin
         dat_o <= rdata_next;
      end
   end

   // ----------------------------------------
   // Request capture
   // ----------------------------------------
   // A set pulse shorter than a character is latched so it is never lost
   assign brk_rise = wr_ctrl && dat_i[`SBG_CTRL_BRK] && !brk_bit;
   assign txen_rise = wr_ctrl && dat_i[`SBG_CTRL_TXEN] && !txen_bit;

   // Requests are looked at only between characters
   assign boundary = (state_reg == S_IDLE) || frame_end;
   assign take_idle = boundary && idle_pend_reg && txen_bit;
   assign take_brk = boundary && !take_idle && txen_bit && (brk_pend_reg || brk_bit);

   always @* begin
      brk_pend_next = brk_pend_reg;
      idle_pend_next = idle_pend_reg;
      // Set wins over the consume in the same cycle
      if (brk_rise) begin
         brk_pend_next = 1'b1;
      end else if (take_brk) begin
         brk_pend_next = 1'b0;
      end
      if (txen_rise) begin
         idle_pend_next = 1'b1;
      end else if (take_idle) begin
         idle_pend_next = 1'b0;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         brk_pend_reg <= 1'b0;
         idle_pend_reg <= 1'b0;
      end else begin
         brk_pend_reg <= brk_pend_next;
         idle_pend_reg <= idle_pend_next;
      end
   end

   // ----------------------------------------
   // Bit timing
   // ----------------------------------------
   // Divisor is frozen per character; a rewrite mid-break does not stretch it
   assign line_run = (state_reg != S_IDLE);

   sbg_baud_tick sbg_baud_tick_i (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(line_run),
      .div_i(div_reg),
      .tick_o(tick)
   );

   assign frame_end = tick && (bit_cnt_reg == len_reg - 4'h1);

   // ----------------------------------------
   // Frame sequencer
   // ----------------------------------------
   always @* begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      len_next = len_reg;
      div_next = div_reg;
      brk_count_next = brk_count_reg;
      if (take_idle) begin
         state_next = S_IDLEFR;
      end else if (take_brk) begin
         // Counter restarts, so idle-then-break keeps nominal length
         state_next = S_BREAK;
         brk_count_next = brk_count_reg + 32'h00000001;
      end else if (frame_end) begin
         state_next = S_IDLE;
      end
      if (take_idle || take_brk || frame_end) begin
         bit_cnt_next = 4'h0;
      end else if (tick) begin
         bit_cnt_next = bit_cnt_reg + 4'h1;
      end
      if (take_idle || take_brk) begin
         // Word length and divisor hold for the whole character
         len_next = char_len;
         div_next = baud_reg;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= S_IDLE;
         bit_cnt_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
      end
   end

   // Character shape held for the whole frame
   always @(posedge clk_i) begin
      if (rst_i) begin
         len_reg <= `SBG_BITS_SHORT;
         div_reg <= `SBG_BAUD_RST;
      end else begin
         len_reg <= len_next;
         div_reg <= div_next;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         brk_count_reg <= 32'h00000000;
      end else begin
         brk_count_reg <= brk_count_next;
      end
   end

   // ----------------------------------------
   // Line driver
   // ----------------------------------------
   // Driven from flip-flops so the pin never glitches between states
   always @* begin
      txd_next = (state_next != S_BREAK);
      busy_next = (state_next != S_IDLE);
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         txd_o <= 1'b1;
         busy_o <= 1'b0;
      end else begin
         txd_o <= txd_next;
         busy_o <= busy_next;
      end
   end

endmodule

/* verif/sbg_chk.sv */
// Port checker of the break generator
module sbg_chk (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [31:0] dat_o,
   input wire ack_o,
   input wire txd_o,
   input wire busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
   ack_due_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
   rst_state_a: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> txd_o && !busy_o && !ack_o && dat_o == 32'h0) else $error("bad reset state");
   hole_zero_a: assert property (ack_o && !we_i && adr_i == 4'hC |-> dat_o == 32'h0) else $error("hole read");
   low_busy_a: assert property (!txd_o |-> busy_o) else $error("line low when not busy");
   brk_min_a: assert property ($fell(txd_o) |-> !txd_o [*8]) else $error("break too short");
   end_mark_a: assert property ($fell(busy_o) |-> txd_o) else $error("line low after frame");
   cover property ($fell(txd_o));
   cover property (busy_o && txd_o);
   cover property (ack_o && we_i);
endmodule

/* verif/sbg_line_rx.sv */
// Remote line receiver that times each low run on the transmit line
module sbg_line_rx (
   input wire clk_i,
   input wire rst_i,
   input wire txd_i,
   output logic [15:0] low_len_o,
   output logic [7:0] brk_cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] run_reg;
   // Back-to-back breaks merge into one run, as on a real wire
   always @(posedge clk_i) begin
      if (rst_i) begin
         run_reg <= 16'h0;
         low_len_o <= 16'h0;
         brk_cnt_o <= 8'h0;
      end else if (!txd_i) begin
         run_reg <= run_reg + 16'h1;
      end else if (run_reg != 16'h0) begin
         low_len_o <= run_reg;
         brk_cnt_o <= brk_cnt_o + 8'h1;
         run_reg <= 16'h0;
      end
   end
endmodule

/* verif/tb_sbg_break_gen.sv */
// Self-checking bench of the break generator
`include "sbg_defines.vh"
module tb_sbg_break_gen;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [3:0] sel_i = 4'h0;
   logic [3:0] adr_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   wire [31:0] dat_o;
   wire ack_o;
   wire txd_o;
   wire busy_o;
   wire [15:0] low_len;
   wire [7:0] brk_cnt;
   logic [31:0] rd;
   logic [3:0] bits_tab [2] = '{4'hA, 4'hB};
   int err_count = 0;
   int comparisons = 0;
   sbg_break_gen sbg_break_gen_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .txd_o(txd_o), .busy_o(busy_o));
   sbg_line_rx sbg_line_rx_i (.clk_i(clk_i), .rst_i(rst_i), .txd_i(txd_o), .low_len_o(low_len),
      .brk_cnt_o(brk_cnt));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'hF;
      adr_i <= a;
      dat_i <= d;
      // Only the watchdog ends a wait for ack
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic wait_done(input logic [7:0] cnt);
      int n = 0;
      while ((brk_cnt !== cnt || busy_o !== 1'b0) && n++ < 2000) @(posedge clk_i);
      check("brk_cnt", brk_cnt, cnt);
   endtask
   task automatic end_sim;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial forever #5 clk_i = ~clk_i;
   // Whole run needs a few hundred cycles
   initial begin
      #100us;
      err_count++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, `SBG_OFS_BAUD, 32'h0);
      check("baud_rst", rd, 32'h363);
      wb(1'b1, `SBG_OFS_BAUD, 32'h1);
      wb(1'b0, 4'hC, 32'h0);
      check("unmapped", rd, 32'h0);
      for (int i = 0; i < 2; i++) begin
         wb(1'b1, `SBG_OFS_CTRL, 32'h0);
         wb(1'b1, `SBG_OFS_CTRL, 32'h2 | (i << 2));
         wb(1'b1, `SBG_OFS_CTRL, 32'h3 | (i << 2));
         wb(1'b1, `SBG_OFS_CTRL, 32'h2 | (i << 2));
         check("idle_busy", busy_o, 32'h1);
         check("idle_txd", txd_o, 32'h1);
         wait_done(i + 1);
         // Divisor 1 gives two clocks a bit
         check("brk_bits", low_len, bits_tab[i] * 32'h2);
      end
      wb(1'b1, `SBG_OFS_CTRL, 32'h3);
      repeat (60) @(posedge clk_i);
      wb(1'b1, `SBG_OFS_CTRL, 32'h2);
      wait_done(8'h3);
      check("held_len", low_len >= 16'h28, 32'h1);
      check("held_whole", low_len % 16'h14, 32'h0);
      wb(1'b0, `SBG_OFS_STAT, 32'h0);
      check("stat_idle", rd[3:0], 32'h0);
      check("stat_count", rd[31:4], 32'h2 + low_len / 16'h14);
      wb(1'b1, `SBG_OFS_CTRL, 32'h3);
      repeat (30) @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("rst_txd", txd_o, 32'h1);
      check("rst_busy", busy_o, 32'h0);
      wb(1'b0, `SBG_OFS_CTRL, 32'h0);
      check("ctrl_rst", rd, 32'h0);
      end_sim();
   end
endmodule
bind sbg_break_gen sbg_chk sbg_chk_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .txd_o(txd_o), .busy_o(busy_o));
